// [hdl/pmps_pkg.sv]
// Purpose: Shared constants of the pixel mask and palette select block.
// Assumes: 8-bit pixel words and an 8-bit processor data port.
// Notes: Palette entries always hold three 8-bit components; 6-bit mode zeroes the top two.
package pmps_pkg;
  // Widths of the pixel, data and palette paths.
  localparam int PIX_W = 8;
  localparam int DATA_W = 8;
  localparam int COMP_W = 8;
  localparam int NARROW_W = 6;
  localparam int ENTRY_W = 3 * COMP_W;
  localparam int PAL_DEPTH = 256;
  localparam int FIFO_DEPTH = 8;
  localparam int SEL_W = 3;

  // Mask value after reset: all ones, so pixels pass through unchanged.
  localparam logic [PIX_W-1:0] MASK_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // Register-select codes.
  localparam logic [SEL_W-1:0] SEL_WR_ADDR = 3'h0;
  localparam logic [SEL_W-1:0] SEL_PAL_DATA = 3'h1;
  localparam logic [SEL_W-1:0] SEL_MASK = 3'h2;
  localparam logic [SEL_W-1:0] SEL_RD_ADDR = 3'h3;

  // Component positions inside one palette entry.
  localparam int RED_LSB = 16;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 0;

  // Which component the next palette data access touches.
  typedef enum logic [1:0] {
    PMPS_COMP_RED = 2'b00,
    PMPS_COMP_GREEN = 2'b01,
    PMPS_COMP_BLUE = 2'b10
  } pmps_comp_e;
endpackage : pmps_pkg

// [hdl/pmps_fifo.sv]
// Purpose: Small synchronous FIFO that buffers incoming pixel words.
// Assumes: One clock; DEPTH is a power of two.
// Notes: in_ready is registered, so it is honest one cycle ahead of a push.
module pmps_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Filling side.
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side.
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths the pointer arithmetic cannot serve.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("pmps_fifo: DEPTH must be a power of two, at least 2.");
  end

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic ready;
  } pmps_fifo_s;

  pmps_fifo_s st_reg;
  pmps_fifo_s st_next;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid && st_reg.ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (st_reg.count != '0);
  assign out_data = mem[st_reg.rptr];
  assign in_ready = st_reg.ready;

  // Pointer and occupancy update; ready drops as the last slot fills.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    st_next.count = st_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    st_next.ready = (st_next.count != (AW + 1)'(DEPTH));
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{wptr: '0, rptr: '0, count: '0, ready: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage carries no reset; only words already counted are ever read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wptr] <= in_data;
    end
  end
endmodule : pmps_fifo

// [hdl/pmps_core.sv]
// Purpose: Pixel input path with read mask, colour table and processor port.
// Assumes: All inputs synchronous to sys_clk; strobes are one-cycle pulses.
// Notes: Pixels are buffered in a FIFO; the colour output stalls on color_ready.
module pmps_core #(
  parameter int SEL_INPUTS = pmps_pkg::SEL_W,
  parameter int FIFO_DEPTH = pmps_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic arst_n,
  // Processor port.
  input wire logic reg_select_hi,
  input wire logic reg_select_mid,
  input wire logic reg_select_lo,
  input wire logic cpu_wr_en,
  input wire logic cpu_rd_en,
  input wire logic [pmps_pkg::DATA_W-1:0] cpu_data_in,
  output logic [pmps_pkg::DATA_W-1:0] cpu_data_out,
  output logic cpu_data_oe,
  // Colour resolution: high selects 8-bit components.
  input wire logic res_8bit_sel,
  // Pixel input.
  input wire logic [pmps_pkg::PIX_W-1:0] pixel_in_bus,
  input wire logic pixel_in_valid,
  output logic pixel_in_ready,
  // Colour output.
  output logic [pmps_pkg::COMP_W-1:0] red_out,
  output logic [pmps_pkg::COMP_W-1:0] green_out,
  output logic [pmps_pkg::COMP_W-1:0] blue_out,
  output logic color_valid,
  input wire logic color_ready
);
  localparam int CW = pmps_pkg::COMP_W;

  // Only the two-input and three-input select variants exist.
  if (SEL_INPUTS != 2 && SEL_INPUTS != 3) begin : g_chk
    $error("pmps_core: SEL_INPUTS must be 2 or 3.");
  end

  typedef struct packed {
    logic [pmps_pkg::PIX_W-1:0] mask;
    logic [pmps_pkg::PIX_W-1:0] addr;
    logic read_mode;
    pmps_pkg::pmps_comp_e comp;
    logic [2*CW-1:0] hold;
    logic [pmps_pkg::DATA_W-1:0] dout;
    logic oe;
    logic [pmps_pkg::PIX_W-1:0] idx;
    logic [CW-1:0] red;
    logic [CW-1:0] green;
    logic [CW-1:0] blue;
    logic cval;
  } pmps_core_s;

  pmps_core_s st_reg;
  pmps_core_s st_next;
  logic [pmps_pkg::ENTRY_W-1:0] palette [pmps_pkg::PAL_DEPTH];
  logic [pmps_pkg::PIX_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic pop;
  logic [pmps_pkg::SEL_W-1:0] sel;
  logic [pmps_pkg::PIX_W-1:0] masked;
  logic [pmps_pkg::ENTRY_W-1:0] look_entry;
  logic [pmps_pkg::ENTRY_W-1:0] cpu_entry;
  logic pal_we;
  logic [pmps_pkg::ENTRY_W-1:0] pal_wdata;

  // Select code; the top input is ignored on the two-input variant.
  function automatic logic [pmps_pkg::SEL_W-1:0] sel_code(input logic hi, input logic mid, input logic lo);
    sel_code = {(SEL_INPUTS == 3) ? hi : 1'b0, mid, lo};
  endfunction : sel_code

  // Trim a component to the chosen resolution; the narrow mode keeps six bits.
  function automatic logic [CW-1:0] fit_comp(input logic [CW-1:0] d, input logic wide);
    fit_comp = wide ? d : {(CW - pmps_pkg::NARROW_W)'(1'b0), d[pmps_pkg::NARROW_W-1:0]};
  endfunction : fit_comp

  // Pick one component out of a palette entry.
  function automatic logic [CW-1:0] comp_of(input logic [pmps_pkg::ENTRY_W-1:0] e, input int lsb);
    comp_of = e[lsb +: CW];
  endfunction : comp_of

  pmps_fifo #(
    .W(pmps_pkg::PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .arst_n(arst_n),
    .in_data(pixel_in_bus),
    .in_valid(pixel_in_valid),
    .in_ready(pixel_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  // Pixel side: the FIFO drains only when the colour stage can move.
  assign fifo_ready = !st_reg.cval || color_ready;
  assign pop = fifo_valid && fifo_ready;
  assign sel = sel_code(reg_select_hi, reg_select_mid, reg_select_lo);
  // The mask is applied in the same cycle as the lookup, so it costs no extra stage.
  assign masked = fifo_data & st_reg.mask;
  assign look_entry = palette[masked];
  assign cpu_entry = palette[st_reg.addr];

  // Palette writes: the third data byte commits the whole entry.
  assign pal_we = cpu_wr_en && sel == pmps_pkg::SEL_PAL_DATA && st_reg.comp == pmps_pkg::PMPS_COMP_BLUE;
  assign pal_wdata = {st_reg.hold, fit_comp(cpu_data_in, res_8bit_sel)};

  // Next state of the processor port and the colour stage.
  always_comb begin
    st_next = st_reg;
    st_next.oe = 1'b0;
    // Processor accesses never wait for pixel timing; both paths run side by side.
    if (cpu_wr_en) begin
      unique case (sel)
        pmps_pkg::SEL_WR_ADDR, pmps_pkg::SEL_RD_ADDR: begin
          st_next.addr = cpu_data_in;
          st_next.read_mode = (sel == pmps_pkg::SEL_RD_ADDR);
          st_next.comp = pmps_pkg::PMPS_COMP_RED;
        end
        pmps_pkg::SEL_PAL_DATA: begin
          unique case (st_reg.comp)
            pmps_pkg::PMPS_COMP_RED: begin
              st_next.hold[CW +: CW] = fit_comp(cpu_data_in, res_8bit_sel);
              st_next.comp = pmps_pkg::PMPS_COMP_GREEN;
            end
            pmps_pkg::PMPS_COMP_GREEN: begin
              st_next.hold[0 +: CW] = fit_comp(cpu_data_in, res_8bit_sel);
              st_next.comp = pmps_pkg::PMPS_COMP_BLUE;
            end
            default: begin
              st_next.addr = st_reg.addr + 8'h01;
              st_next.comp = pmps_pkg::PMPS_COMP_RED;
            end
          endcase
        end
        pmps_pkg::SEL_MASK: begin
          st_next.mask = cpu_data_in;
        end
        default: begin
        end
      endcase
    end else if (cpu_rd_en) begin
      st_next.oe = 1'b1;
      unique case (sel)
        pmps_pkg::SEL_WR_ADDR, pmps_pkg::SEL_RD_ADDR: begin
          st_next.dout = st_reg.addr;
        end
        pmps_pkg::SEL_PAL_DATA: begin
          unique case (st_reg.comp)
            pmps_pkg::PMPS_COMP_RED: begin
              st_next.dout = fit_comp(comp_of(cpu_entry, pmps_pkg::RED_LSB), res_8bit_sel);
              st_next.comp = pmps_pkg::PMPS_COMP_GREEN;
            end
            pmps_pkg::PMPS_COMP_GREEN: begin
              st_next.dout = fit_comp(comp_of(cpu_entry, pmps_pkg::GREEN_LSB), res_8bit_sel);
              st_next.comp = pmps_pkg::PMPS_COMP_BLUE;
            end
            default: begin
              st_next.dout = fit_comp(comp_of(cpu_entry, pmps_pkg::BLUE_LSB), res_8bit_sel);
              st_next.addr = st_reg.addr + 8'h01;
              st_next.comp = pmps_pkg::PMPS_COMP_RED;
            end
          endcase
        end
        pmps_pkg::SEL_MASK: begin
          st_next.dout = st_reg.mask;
        end
        default: begin
          st_next.dout = pmps_pkg::ZERO_BYTE;
        end
      endcase
    end
    // Colour stage: one lookup per popped pixel, held while the sink stalls.
    if (pop) begin
      st_next.idx = masked;
      st_next.red = fit_comp(comp_of(look_entry, pmps_pkg::RED_LSB), res_8bit_sel);
      st_next.green = fit_comp(comp_of(look_entry, pmps_pkg::GREEN_LSB), res_8bit_sel);
      st_next.blue = fit_comp(comp_of(look_entry, pmps_pkg::BLUE_LSB), res_8bit_sel);
      st_next.cval = 1'b1;
    end else if (color_ready) begin
      st_next.cval = 1'b0;
    end
  end

  // State register; the mask starts transparent.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.mask <= pmps_pkg::MASK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Palette storage; contents are undefined until software loads them.
  always_ff @(posedge sys_clk) begin
    if (pal_we) begin
      palette[st_reg.addr] <= pal_wdata;
    end
  end

  assign cpu_data_out = st_reg.dout;
  assign cpu_data_oe = st_reg.oe;
  assign red_out = st_reg.red;
  assign green_out = st_reg.green;
  assign blue_out = st_reg.blue;
  assign color_valid = st_reg.cval;

  a_mask_and_index: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pop |=> st_reg.idx == ($past(fifo_data) & $past(st_reg.mask)))
    else $error("Colour index is not the pixel ANDed with the mask.");

  a_table_lookup: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pop && res_8bit_sel |=> red_out == $past(look_entry[pmps_pkg::RED_LSB +: CW]) && color_valid)
    else $error("Red output does not come from the masked table entry.");

  a_mask_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cpu_wr_en && sel == pmps_pkg::SEL_MASK |=> st_reg.mask == $past(cpu_data_in))
    else $error("Mask write did not land.");

  a_mask_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !cpu_wr_en && cpu_rd_en && sel == pmps_pkg::SEL_MASK |=> cpu_data_oe && cpu_data_out == $past(st_reg.mask))
    else $error("Mask read returned the wrong value.");

  a_transparent_mask: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pop && st_reg.mask == pmps_pkg::MASK_RESET |=> st_reg.idx == $past(fifo_data))
    else $error("All-ones mask altered the pixel.");

  a_addr_mode_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cpu_wr_en && (sel == pmps_pkg::SEL_WR_ADDR || sel == pmps_pkg::SEL_RD_ADDR)
    |=> st_reg.addr == $past(cpu_data_in) && st_reg.read_mode == ($past(sel) == pmps_pkg::SEL_RD_ADDR))
    else $error("Address register or its mode was not set.");

  a_entry_commit: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pal_we |=> st_reg.addr == $past(st_reg.addr) + 8'h01 && st_reg.comp == pmps_pkg::PMPS_COMP_RED)
    else $error("Palette entry commit did not advance the address.");

  a_narrow_comp: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(pop) && !$past(res_8bit_sel)
    |-> red_out[CW-1:pmps_pkg::NARROW_W] == '0 && green_out[CW-1:pmps_pkg::NARROW_W] == '0
    && blue_out[CW-1:pmps_pkg::NARROW_W] == '0)
    else $error("Narrow mode produced an 8-bit component.");

  a_no_latency: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cpu_wr_en && sel == pmps_pkg::SEL_MASK ##1 pop |=> st_reg.idx == ($past(fifo_data) & $past(cpu_data_in, 2)))
    else $error("Pixel after a mask write did not use the new mask.");

  // Green and blue follow the same masked entry as red.
  a_green_blue_lookup: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pop && res_8bit_sel |=> green_out == $past(look_entry[pmps_pkg::GREEN_LSB +: CW])
    && blue_out == $past(look_entry[pmps_pkg::BLUE_LSB +: CW]))
    else $error("Green or blue output does not come from the masked table entry.");

  // Only a processor write may move the mask; pixel traffic never touches it.
  a_mask_held: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(cpu_wr_en && sel == pmps_pkg::SEL_MASK) |=> st_reg.mask == $past(st_reg.mask))
    else $error("Mask changed without a mask write.");

  // The data bus is driven only in answer to a read strobe.
  a_oe_after_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cpu_data_oe |-> $past(cpu_rd_en) && !$past(cpu_wr_en))
    else $error("Data bus driven without a read.");

  // On the three-input variant the top select input leads to no register.
  a_unused_read_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !cpu_wr_en && cpu_rd_en && reg_select_hi && SEL_INPUTS == 3 |=> cpu_data_oe && cpu_data_out == pmps_pkg::ZERO_BYTE)
    else $error("Unused select code returned data.");

  // Reading the red byte gives the stored red component of the addressed entry.
  a_pal_read_data: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !cpu_wr_en && cpu_rd_en && sel == pmps_pkg::SEL_PAL_DATA && st_reg.comp == pmps_pkg::PMPS_COMP_RED
    && res_8bit_sel |=> cpu_data_out == $past(cpu_entry[pmps_pkg::RED_LSB +: CW]))
    else $error("Palette read returned the wrong red byte.");

  // The third read byte finishes the entry and steps the address, as a write does.
  a_pal_read_advance: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !cpu_wr_en && cpu_rd_en && sel == pmps_pkg::SEL_PAL_DATA && st_reg.comp == pmps_pkg::PMPS_COMP_BLUE
    |=> st_reg.addr == $past(st_reg.addr) + 8'h01 && st_reg.comp == pmps_pkg::PMPS_COMP_RED)
    else $error("Palette read did not advance the address.");

  // A held colour word must not change under a stalled sink.
  a_colour_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    color_valid && !color_ready |=> color_valid && $stable(red_out) && $stable(green_out) && $stable(blue_out))
    else $error("Colour word changed while the sink stalled.");

  // Main scenarios that the bench must reach.
  c_mask_write: cover property (@(posedge sys_clk) disable iff (!arst_n)
    cpu_wr_en && sel == pmps_pkg::SEL_MASK);
  c_masked_pixel: cover property (@(posedge sys_clk) disable iff (!arst_n)
    pop && st_reg.mask != pmps_pkg::MASK_RESET);
  c_fifo_full: cover property (@(posedge sys_clk) disable iff (!arst_n) !pixel_in_ready);
  c_entry_commit: cover property (@(posedge sys_clk) disable iff (!arst_n) pal_we);
  c_mask_then_pop: cover property (@(posedge sys_clk) disable iff (!arst_n)
    cpu_wr_en && sel == pmps_pkg::SEL_MASK ##1 pop);
endmodule : pmps_core

// [tb/pmps_pix_src.sv]
// Purpose: Frame buffer side model that feeds pixel words to the core.
// Assumes: One clock; the core takes a word on an edge with valid and ready high.
// Notes: In idle cycles the bus toggles, so a stale word can never pass for a fresh one.
module pmps_pix_src (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pacing: high leaves an idle cycle before each word.
  input wire logic slow,
  // Pixel stream.
  output logic [7:0] pixel_in_bus,
  output logic pixel_in_valid,
  input wire logic pixel_in_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pend [$];
  logic gap_reg = 1'b0;

  // Known bus levels before the first edge.
  initial begin
    pixel_in_bus = 8'h5A;
    pixel_in_valid = 1'b0;
  end

  // Words queued by the bench, sent in order.
  task automatic send(input logic [7:0] p);
    pend.push_back(p);
  endtask : send

  // A word holds until an edge sees ready; only then the next word or idle follows.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pixel_in_valid <= 1'b0;
      gap_reg <= 1'b0;
    end else if (!pixel_in_valid || pixel_in_ready) begin
      gap_reg <= slow && !gap_reg;
      if (pend.size() != 0 && !(slow && !gap_reg)) begin
        pixel_in_bus <= pend.pop_front();
        pixel_in_valid <= 1'b1;
      end else begin
        pixel_in_bus <= ~pixel_in_bus;
        pixel_in_valid <= 1'b0;
      end
    end
  end
endmodule : pmps_pix_src

// [tb/pmps_core_tb.sv]
// Purpose: Self-checking bench for the pixel mask and palette select core.
// Assumes: 25 MHz clock; read data one cycle after its strobe, colours after FIFO and colour stage.
// Notes: Buffered pixels see the mask at pop time, so a live mask change is timed against a held sink.
module pmps_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] sel = 3'h0;
  logic cpu_wr_en = 1'b0;
  logic cpu_rd_en = 1'b0;
  logic [7:0] cpu_data_in = 8'h00;
  logic [7:0] cpu_data_out;
  logic cpu_data_oe;
  logic res_8bit_sel = 1'b1;
  logic [7:0] pixel_in_bus;
  logic pixel_in_valid;
  logic pixel_in_ready;
  logic [7:0] red_out;
  logic [7:0] green_out;
  logic [7:0] blue_out;
  logic color_valid;
  logic color_ready = 1'b0;
  logic stall = 1'b1;
  logic steady = 1'b0;
  logic slow = 1'b0;
  integer seed = 49;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] mask_m = 8'hFF;
  logic [23:0] pal_m [256];
  logic [7:0] rdq [$];
  logic [23:0] colq [$];

  // Clock of 40 ns period.
  always #20 sys_clk = ~sys_clk;

  pmps_core DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_select_hi(sel[2]), .reg_select_mid(sel[1]),
    .reg_select_lo(sel[0]), .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en), .cpu_data_in(cpu_data_in),
    .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe), .res_8bit_sel(res_8bit_sel),
    .pixel_in_bus(pixel_in_bus), .pixel_in_valid(pixel_in_valid), .pixel_in_ready(pixel_in_ready),
    .red_out(red_out), .green_out(green_out), .blue_out(blue_out), .color_valid(color_valid),
    .color_ready(color_ready));

  pmps_pix_src src (.sys_clk(sys_clk), .arst_n(arst_n), .slow(slow), .pixel_in_bus(pixel_in_bus),
    .pixel_in_valid(pixel_in_valid), .pixel_in_ready(pixel_in_ready));

  // Colour sink stalls at random, wholly while stall is set, never while steady is set and stall is clear.
  always @(posedge sys_clk) begin
    color_ready <= !stall && (steady || (($random(seed) & 3) != 0));
  end

  task automatic err(input string m);
    failures++;
    $display("ERROR %0t %s", $time, m);
  endtask : err

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err($sformatf("%s got %h expected %h", m, got, exp));
    end
  endtask : chk

  // Each result seen at the ports retires the oldest note of its kind.
  always @(posedge sys_clk) begin
    if (arst_n && cpu_data_oe === 1'b1) begin
      if (rdq.size() == 0) err("read data without a read");
      else chk({16'h0000, cpu_data_out}, {16'h0000, rdq.pop_front()}, "read");
    end
    if (arst_n && color_valid === 1'b1 && color_ready === 1'b1) begin
      if (colq.size() == 0) err("colour without a pixel");
      else chk({red_out, green_out, blue_out}, colq.pop_front(), "colour");
    end
  end

  task automatic reg_wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    sel <= s;
    cpu_data_in <= d;
    cpu_wr_en <= 1'b1;
    @(posedge sys_clk);
    cpu_wr_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] s, input logic [7:0] e);
    @(posedge sys_clk);
    sel <= s;
    cpu_rd_en <= 1'b1;
    rdq.push_back(e);
    @(posedge sys_clk);
    cpu_rd_en <= 1'b0;
  endtask : reg_rd

  // Expected colour is reckoned when the pixel is handed over.
  task automatic pix(input logic [7:0] p);
    logic [23:0] e;
    e = pal_m[p & mask_m];
    if (!res_8bit_sel) e = e & 24'h3F3F3F;
    colq.push_back(e);
    src.send(p);
  endtask : pix

  task automatic pal_rd2(input logic [7:0] a);
    reg_wr(pmps_pkg::SEL_RD_ADDR, a);
    for (int i = 0; i < 6; i++) reg_rd(pmps_pkg::SEL_PAL_DATA, pal_m[a + i / 3][(2 - i % 3) * 8 +: 8]);
  endtask : pal_rd2

  task automatic drain();
    int n;
    n = 0;
    while (colq.size() != 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (colq.size() != 0) err("pixels not delivered");
    repeat (3) @(posedge sys_clk);
  endtask : drain

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Main sequence.
  initial begin
    logic [23:0] v;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    reg_rd(pmps_pkg::SEL_MASK, pmps_pkg::MASK_RESET);
    @(posedge sys_clk);
    chk({23'h0, pixel_in_ready}, 24'h1, "ready after reset");
    $display("test reset done");
    // One address write, then the address steps after every third byte.
    reg_wr(pmps_pkg::SEL_WR_ADDR, 8'h00);
    for (int a = 0; a < 256; a++) begin
      v = 24'($random(seed));
      pal_m[a] = v;
      for (int i = 2; i >= 0; i--) reg_wr(pmps_pkg::SEL_PAL_DATA, v[i * 8 +: 8]);
    end
    // A stray byte is dropped when the address is written again.
    reg_wr(pmps_pkg::SEL_WR_ADDR, 8'h0A);
    reg_wr(pmps_pkg::SEL_PAL_DATA, 8'h55);
    reg_wr(pmps_pkg::SEL_WR_ADDR, 8'h0A);
    pal_m[8'h0A] = 24'hC3A51E;
    for (int i = 2; i >= 0; i--) reg_wr(pmps_pkg::SEL_PAL_DATA, pal_m[8'h0A][i * 8 +: 8]);
    pal_rd2(8'h09);
    pal_rd2(8'hFE);
    $display("test palette done");
    // Transparent mask, paced source, mask read while pixels flow.
    stall <= 1'b0;
    slow <= 1'b1;
    for (int i = 0; i < 40; i++) pix(8'($random(seed)));
    reg_rd(pmps_pkg::SEL_MASK, 8'hFF);
    drain();
    slow <= 1'b0;
    $display("test stream done");
    // Step through eight masks, sixteen random pixels under each.
    for (int k = 0; k < 8; k++) begin
      mask_m = {1'b1, 3'(k), 4'hF};
      reg_wr(pmps_pkg::SEL_MASK, mask_m);
      reg_rd(pmps_pkg::SEL_MASK, mask_m);
      for (int i = 0; i < 16; i++) pix(8'($random(seed)));
      drain();
    end
    $display("test planes done");
    // Unused select codes store nothing and read back as zero.
    for (int s = 4; s < 8; s++) begin
      reg_wr(3'(s), 8'h00);
      reg_rd(3'(s), 8'h00);
    end
    reg_rd(pmps_pkg::SEL_MASK, mask_m);
    $display("test unused codes done");
    // Narrow components: top two bits read as zero.
    @(posedge sys_clk);
    res_8bit_sel <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 16; i++) pix(8'($random(seed)));
    drain();
    reg_wr(pmps_pkg::SEL_RD_ADDR, 8'h20);
    for (int i = 2; i >= 0; i--) reg_rd(pmps_pkg::SEL_PAL_DATA, pal_m[8'h20][i * 8 +: 8] & 8'h3F);
    $display("test narrow done");
    // Full buffer refuses pixels, register port still answers.
    stall <= 1'b1;
    for (int i = 0; i < 14; i++) pix(8'($random(seed)));
    repeat (20) @(posedge sys_clk);
    chk({23'h0, pixel_in_ready}, 24'h0, "ready while full");
    reg_rd(pmps_pkg::SEL_MASK, mask_m);
    stall <= 1'b0;
    drain();
    chk({23'h0, pixel_in_ready}, 24'h1, "ready after drain");
    $display("test full buffer done");
    // Mask rewritten while pixels wait; only the word already looked up keeps the old mask.
    stall <= 1'b1;
    pix(8'($random(seed)));
    mask_m = 8'h9F;
    for (int i = 0; i < 6; i++) pix(8'($random(seed)));
    repeat (20) @(posedge sys_clk);
    // The sink opens on the same edge that takes the write, so the next pop follows it directly.
    fork
      reg_wr(pmps_pkg::SEL_MASK, mask_m);
      begin
        @(posedge sys_clk);
        stall <= 1'b0;
        steady <= 1'b1;
      end
    join
    reg_rd(pmps_pkg::SEL_MASK, mask_m);
    drain();
    steady <= 1'b0;
    chk(24'(rdq.size()), 24'h0, "reads left unanswered");
    $display("test live mask done");
    conclude();
  end

  // Watchdog cuts a hang short well above the expected run length.
  initial begin
    repeat (40000) @(posedge sys_clk);
    err("watchdog expired");
    conclude();
  end
endmodule : pmps_core_tb
